// File: common/tcit_pkg.sv
package tcit_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clocking
    localparam int CLK_HZ = 25_000_000;
    localparam int INT_CLK_HZ = 1_000_000;
    // counter 0 external clock ceiling; needs at least one sys_clk low and high
    localparam int EXT_CLK_MAX_HZ = 10_000_000;
    localparam int INT_DIV = CLK_HZ / INT_CLK_HZ;
    localparam logic [4:0] DIV_LAST = 5'(INT_DIV - 1);
    localparam int NUM_CNT = 3;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [3:0] OFS_CNT0 = 4'h8;
    localparam logic [3:0] OFS_CNT1 = 4'h9;
    localparam logic [3:0] OFS_CNT2 = 4'hA;
    localparam logic [3:0] OFS_CTRL = 4'hB;

    ////////////////////////////////////////////////////////////////////////////
    // control byte fields
    localparam int CW_SEL_LO = 6;
    localparam int CW_ACC_LO = 4;
    localparam int CW_MODE_LO = 1;
    localparam int CW_BCD = 0;
    localparam int RB_CNT_N = 5;
    localparam int RB_STA_N = 4;
    localparam int RB_SEL_LO = 1;
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] ACC_LATCH = 2'h0;
    localparam logic [1:0] ACC_LOW = 2'h1;
    localparam logic [1:0] ACC_HIGH = 2'h2;
    localparam logic [1:0] ACC_BOTH = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [7:0] RD_IDLE = 8'h00;
    localparam logic [1:0] ACC_RESET = ACC_BOTH;

    typedef enum logic [2:0] {
        TCIT_M0,
        TCIT_M1,
        TCIT_M2,
        TCIT_M3,
        TCIT_M4,
        TCIT_M5
    } tcit_mode_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
        logic wr;
        logic rd;
    } tcit_bus_t;

    typedef struct packed {
        tcit_mode_t mode;
        logic [2:0] modeRaw;
        logic [1:0] access;
        logic bcd;
        logic [15:0] cr;
        logic [15:0] ce;
        logic [15:0] hold;
        logic [7:0] status;
        logic holdValid;
        logic statusValid;
        logic wrHigh;
        logic rdHigh;
        logic pending;
        logic armed;
        logic active;
        logic extra;
        logic trig;
        logic out;
    } tcit_chan_t;

    typedef struct packed {
        tcit_chan_t [NUM_CNT-1:0] chan;
        logic [4:0] divCnt;
        logic [7:0] rdData;
        logic convStart;
    } tcit_state_t;

    localparam tcit_chan_t CHAN_RESET = '{mode: TCIT_M0, access: ACC_RESET, out: 1'b1,
                                          default: '0};
    localparam tcit_state_t STATE_RESET = '{chan: {NUM_CNT{CHAN_RESET}}, rdData: RD_IDLE,
                                            default: '0};

endpackage

// File: hdl/tcit_edge.sv
`timescale 1ns/1ps
`default_nettype none
module tcit_edge #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clkEn,
    // sampled levels and their rising edges
    input wire logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] q;
    logic [W-1:0] d;

    always_comb begin
        d = level;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else if (clkEn) begin
            q <= d;
        end
    end

    // frozen clock enable also freezes edges, so nothing is seen twice
    assign rise = level & ~q & {W{clkEn}};
endmodule
`default_nettype wire

// File: hdl/tcit_dec.sv
`timescale 1ns/1ps
`default_nettype none
module tcit_dec (
    // count and format
    input wire logic [15:0] value,
    input wire logic bcd,
    // decremented counts
    output logic [15:0] minusOne,
    output logic [15:0] minusTwo
);
    function automatic logic [15:0] dec1(input logic [15:0] v, input logic isBcd);
        logic [15:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        if (!isBcd) begin
            r = v - 16'h0001;
        end else begin
            // digit-wise borrow; 0000 wraps to 9999
            for (int k = 0; k < 4; k++) begin
                if (borrow) begin
                    if (v[k*4 +: 4] == 4'h0) begin
                        r[k*4 +: 4] = 4'h9;
                    end else begin
                        r[k*4 +: 4] = v[k*4 +: 4] - 4'h1;
                        borrow = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    always_comb begin
        minusOne = dec1(value, bcd);
        minusTwo = dec1(minusOne, bcd);
    end
endmodule
`default_nettype wire

// File: hdl/tcit_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - three separate sixteen-bit down counters, each preset with a count by software
// - starting counts from 1 or 2 up to 65535 are accepted
// - counter 0 gated by a pin, clocked by internal 1 MHz or external clock
// - counters 1 and 2 cascade into a 32-bit pacer on 1 MHz, software gated
// - gate rising edge is the trigger; one clock is one counter clock pulse
// - mode 0: load drives output low, counts down, output high at zero until reload
// - mode 1: output low after trigger, high at zero; retrigger reloads and restarts
// - mode 2: divide by N, one-clock low pulse, reload, repeats while gate high
// - cascaded pacer in mode 2 gives periodic conversion start pulses
// - mode 3: square wave; odd N gives (N+1)/2 high and (N-1)/2 low
// - mode 3 counts down by two each half, reloading between halves
// - mode 4: output high on load, low one period at zero, gate low inhibits
// - mode 5: gate edge starts count, low one clock at terminal count, retriggerable
// - counter data ports at offsets 8, 9, A read/write; control byte at B
// - control byte: select 7-6, access 5-4, mode 3-1, bcd bit 0
// - select codes 00, 01, 10 pick a counter; 11 is the read-back command
// - access: 00 latch, 01 low byte, 10 high byte, 11 low then high
// - mode bits 000,001,100,101 give modes 0,1,4,5; x10, x11 give 2, 3
// - bcd bit 0 counts binary, 1 counts binary-coded decimal
// - latch copies live count to a hold register; next read returns it
// - two-byte access goes low then high, tracked by a byte toggle
// - mode 0 counting pauses while the gate is low
module tcit_timer
    import tcit_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clkEn,
    // host register window
    input wire tcit_bus_t hostBus,
    output logic [7:0] rdData,
    // counter 0 field connections
    input wire logic ctr0Gate,
    input wire logic ctr0ExtClk,
    input wire logic ctr0ClkSelExt,
    output logic ctr0Out,
    // cascaded pacer
    input wire logic pacerGateEn,
    output logic pacerOut,
    output logic convStart
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    tcit_state_t q;
    tcit_state_t d;
    tcit_chan_t c;
    logic [3:0] edgeIn;
    logic [3:0] edgeRise;
    logic intTick;
    logic [NUM_CNT-1:0] tick;
    logic [NUM_CNT-1:0] gateLvl;
    logic [NUM_CNT-1:0] gateRise;
    logic [15:0] decOne [NUM_CNT];
    logic [15:0] decTwo [NUM_CNT];
    logic trg;
    logic loadNow;
    logic runOk;
    logic [15:0] rdWord;
    logic [1:0] cwSel;
    logic [1:0] cwAcc;
    logic [2:0] cwMode;

    function automatic tcit_mode_t decodeMode(input logic [2:0] raw);
        tcit_mode_t m;
        m = TCIT_M0;
        casez (raw)
            3'b000: m = TCIT_M0;
            3'b001: m = TCIT_M1;
            3'b?10: m = TCIT_M2;
            3'b?11: m = TCIT_M3;
            3'b100: m = TCIT_M4;
            3'b101: m = TCIT_M5;
            default: m = TCIT_M0;
        endcase
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // edges of gates and counter clocks

    // counter 1 output is the clock of counter 2
    assign edgeIn = {q.chan[1].out, pacerGateEn, ctr0ExtClk, ctr0Gate};

    tcit_edge #(
        .W(4)
    ) uEdge (
        .sys_clk(sys_clk),
        .reset(reset),
        .clkEn(clkEn),
        .level(edgeIn),
        .rise(edgeRise)
    );

    for (genvar g = 0; g < NUM_CNT; g++) begin : gDec
        tcit_dec uDec (
            .value(q.chan[g].ce),
            .bcd(q.chan[g].bcd),
            .minusOne(decOne[g]),
            .minusTwo(decTwo[g])
        );
    end

    // external clock is sampled by sys_clk: above about 10 MHz pulses are missed
    always_comb begin
        intTick = (q.divCnt == DIV_LAST);
        tick[0] = ctr0ClkSelExt ? edgeRise[1] : intTick;
        tick[1] = intTick;
        tick[2] = edgeRise[3];
        gateLvl[0] = ctr0Gate;
        gateRise[0] = edgeRise[0];
        gateLvl[1] = pacerGateEn;
        gateRise[1] = edgeRise[2];
        gateLvl[2] = pacerGateEn;
        gateRise[2] = edgeRise[2];
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        c = q.chan[0];
        trg = 1'b0;
        loadNow = 1'b0;
        runOk = 1'b0;
        rdWord = 16'h0000;
        cwSel = hostBus.data[CW_SEL_LO +: 2];
        cwAcc = hostBus.data[CW_ACC_LO +: 2];
        cwMode = hostBus.data[CW_MODE_LO +: 3];
        d.divCnt = intTick ? 5'h00 : q.divCnt + 5'h01;
        if (hostBus.rd) begin
            d.rdData = RD_IDLE;
        end
        for (int i = 0; i < NUM_CNT; i++) begin
            c = q.chan[i];
            // an edge in the consuming cycle is used by that tick, never dropped
            trg = c.trig | gateRise[i];
            c.trig = tick[i] ? 1'b0 : trg;
            if (tick[i]) begin
                case (c.mode)
                    TCIT_M0: begin
                        if (c.pending) begin
                            c.ce = c.cr;
                            c.pending = 1'b0;
                            c.active = 1'b1;
                        end else if (c.active && gateLvl[i]) begin
                            c.ce = decOne[i];
                            if (decOne[i] == 16'h0000) begin
                                c.out = 1'b1;
                            end
                        end
                    end
                    TCIT_M1: begin
                        if (trg && c.armed) begin
                            c.ce = c.cr;
                            c.pending = 1'b0;
                            c.out = 1'b0;
                            c.active = 1'b1;
                        end else if (c.active) begin
                            c.ce = decOne[i];
                            if (decOne[i] == 16'h0000) begin
                                c.out = 1'b1;
                                c.active = 1'b0;
                            end
                        end
                    end
                    TCIT_M2: begin
                        loadNow = (trg && c.armed) || (c.pending && !c.active);
                        if (!gateLvl[i]) begin
                            c.out = 1'b1;
                        end else if (loadNow) begin
                            c.ce = c.cr;
                            c.out = 1'b1;
                            c.active = 1'b1;
                            c.pending = 1'b0;
                        end else if (c.active) begin
                            if (c.ce == 16'h0001) begin
                                // reload is where a count written mid-period takes hold
                                c.ce = c.cr;
                                c.out = 1'b1;
                                c.pending = 1'b0;
                            end else begin
                                c.ce = decOne[i];
                                c.out = (decOne[i] != 16'h0001);
                            end
                        end
                    end
                    TCIT_M3: begin
                        loadNow = (trg && c.armed) || (c.pending && !c.active);
                        if (!gateLvl[i]) begin
                            c.out = 1'b1;
                        end else if (loadNow) begin
                            c.ce = {c.cr[15:1], 1'b0};
                            c.extra = c.cr[0];
                            c.out = 1'b1;
                            c.active = 1'b1;
                            c.pending = 1'b0;
                        end else if (c.active) begin
                            if (c.extra) begin
                                // odd count: high half gets one held clock
                                c.extra = 1'b0;
                            end else if (c.ce <= 16'h0002) begin
                                c.ce = {c.cr[15:1], 1'b0};
                                c.out = ~c.out;
                                c.extra = c.cr[0] & c.out;
                                c.pending = 1'b0;
                            end else begin
                                c.ce = decTwo[i];
                            end
                        end
                    end
                    TCIT_M4, TCIT_M5: begin
                        loadNow = (c.mode == TCIT_M4) ? c.pending : (trg && c.armed);
                        runOk = (c.mode == TCIT_M4) ? gateLvl[i] : 1'b1;
                        c.out = 1'b1;
                        if (loadNow) begin
                            c.ce = c.cr;
                            c.pending = 1'b0;
                            c.active = 1'b1;
                        end else if (c.active && runOk) begin
                            c.ce = decOne[i];
                            if (decOne[i] == 16'h0000) begin
                                c.out = 1'b0;
                                c.active = 1'b0;
                            end
                        end
                    end
                    default: begin
                        c.active = 1'b0;
                    end
                endcase
            end

            // gate low lifts a periodic output at once, even while its clock is stalled
            if ((c.mode == TCIT_M2 || c.mode == TCIT_M3) && !gateLvl[i]) begin
                c.out = 1'b1;
            end

            // data port write
            if (hostBus.wr && hostBus.addr == OFS_CNT0 + 4'(i)) begin
                case (c.access)
                    ACC_LOW: begin
                        c.cr = {8'h00, hostBus.data};
                        c.pending = 1'b1;
                    end
                    ACC_HIGH: begin
                        c.cr = {hostBus.data, 8'h00};
                        c.pending = 1'b1;
                    end
                    ACC_BOTH: begin
                        if (!c.wrHigh) begin
                            c.cr[7:0] = hostBus.data;
                            c.wrHigh = 1'b1;
                        end else begin
                            c.cr[15:8] = hostBus.data;
                            c.wrHigh = 1'b0;
                            c.pending = 1'b1;
                        end
                    end
                    default: begin
                        c.pending = c.pending;
                    end
                endcase
                if (c.pending) begin
                    c.armed = 1'b1;
                    if (c.mode == TCIT_M0) begin
                        c.out = 1'b0;
                        c.active = 1'b0;
                    end
                end
            end

            // control byte
            if (hostBus.wr && hostBus.addr == OFS_CTRL) begin
                if (cwSel == 2'(i)) begin
                    if (cwAcc == ACC_LATCH) begin
                        if (!c.holdValid) begin
                            c.hold = c.ce;
                            c.holdValid = 1'b1;
                        end
                    end else begin
                        c.access = cwAcc;
                        c.modeRaw = cwMode;
                        c.mode = decodeMode(cwMode);
                        c.bcd = hostBus.data[CW_BCD];
                        c.wrHigh = 1'b0;
                        c.rdHigh = 1'b0;
                        c.pending = 1'b0;
                        c.armed = 1'b0;
                        c.active = 1'b0;
                        c.extra = 1'b0;
                        c.holdValid = 1'b0;
                        c.statusValid = 1'b0;
                        c.out = (decodeMode(cwMode) != TCIT_M0);
                    end
                end else if (cwSel == SEL_READBACK && hostBus.data[RB_SEL_LO + i]) begin
                    if (!hostBus.data[RB_CNT_N] && !c.holdValid) begin
                        c.hold = c.ce;
                        c.holdValid = 1'b1;
                    end
                    if (!hostBus.data[RB_STA_N] && !c.statusValid) begin
                        c.status = {c.out, c.pending, c.access, c.modeRaw, c.bcd};
                        c.statusValid = 1'b1;
                    end
                end
            end

            // data port read: status first, then held or live count
            if (hostBus.rd && hostBus.addr == OFS_CNT0 + 4'(i)) begin
                rdWord = c.holdValid ? c.hold : c.ce;
                if (c.statusValid) begin
                    d.rdData = c.status;
                    c.statusValid = 1'b0;
                end else begin
                    case (c.access)
                        ACC_LOW: begin
                            d.rdData = rdWord[7:0];
                            c.holdValid = 1'b0;
                        end
                        ACC_HIGH: begin
                            d.rdData = rdWord[15:8];
                            c.holdValid = 1'b0;
                        end
                        default: begin
                            d.rdData = c.rdHigh ? rdWord[15:8] : rdWord[7:0];
                            if (c.rdHigh) begin
                                c.holdValid = 1'b0;
                            end
                            c.rdHigh = ~c.rdHigh;
                        end
                    endcase
                end
            end
            d.chan[i] = c;
        end
        // conversion start on each low strobe of the pacer
        d.convStart = q.chan[2].out & ~d.chan[2].out;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            q <= STATE_RESET;
        end else if (clkEn) begin
            q <= d;
        end
    end

    assign rdData = q.rdData;
    assign ctr0Out = q.chan[0].out;
    assign pacerOut = q.chan[2].out;
    assign convStart = q.convStart;

endmodule
`default_nettype wire

// File: bench/tcit_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tcit_timer_properties
    import tcit_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clkEn,
    // host window
    input wire tcit_bus_t hostBus,
    input wire logic [7:0] rdData,
    // counters
    input wire logic ctr0Gate,
    input wire logic ctr0ExtClk,
    input wire logic ctr0ClkSelExt,
    input wire logic ctr0Out,
    input wire logic pacerGateEn,
    input wire logic pacerOut,
    input wire logic convStart
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic ctlWr;
    logic [2:0] ctr0Mode_q;
    assign ctlWr = clkEn && hostBus.wr && hostBus.addr == OFS_CTRL
        && hostBus.data[7:6] == 2'h0 && hostBus.data[5:4] != ACC_LATCH;
    // latch commands leave the mode alone
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctr0Mode_q <= 3'h0;
        end else if (ctlWr) begin
            ctr0Mode_q <= hostBus.data[3:1];
        end
    end
    a_read_idle:
    assert property (clkEn && hostBus.rd && (hostBus.addr == OFS_CTRL
        || hostBus.addr < OFS_CNT0) |=> rdData == 8'h00) else $error("idle read not zero");
    a_read_hold:
    assert property (!(clkEn && hostBus.rd) |=> $stable(rdData)) else $error("rdData moved");
    a_conv_fall:
    assert property ($fell(pacerOut) ##0 clkEn[*2] |-> convStart || $past(convStart))
        else $error("no start pulse");
    a_conv_once:
    assert property (convStart && clkEn |=> !convStart) else $error("start pulse too long");
    a_conv_low:
    assert property (convStart |-> !pacerOut) else $error("start while pacer high");
    a_arm_low:
    assert property (ctlWr && hostBus.data[3:1] == 3'h0 |-> ##[1:2] !ctr0Out)
        else $error("mode 0 arm not low");
    a_arm_high:
    assert property (ctlWr && hostBus.data[3:1] != 3'h0 |-> ##[1:2] ctr0Out)
        else $error("arm not high");
    a_m0_stay:
    assert property ((!hostBus.wr)[*2] ##0 (ctr0Mode_q == 3'h0 && ctr0Out) |=> ctr0Out)
        else $error("mode 0 output fell");
    a_m0_pause:
    assert property ((ctr0Mode_q == 3'h0 && !ctr0Out && !ctr0Gate && !hostBus.wr)[*3]
        |=> !ctr0Out) else $error("mode 0 counted gated");
    cover property (convStart);
    cover property ($rose(ctr0Out) && ctr0Mode_q == 3'h0);
    cover property (clkEn && hostBus.rd && hostBus.addr == OFS_CTRL);
endmodule
bind tcit_timer tcit_timer_properties u_props (.sys_clk, .reset, .clkEn, .hostBus, .rdData,
    .ctr0Gate, .ctr0ExtClk, .ctr0ClkSelExt, .ctr0Out, .pacerGateEn, .pacerOut, .convStart);
`default_nettype wire

// File: bench/tcit_host.sv
`timescale 1ns/1ps
`default_nettype none
module tcit_host
    import tcit_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // register window
    output var tcit_bus_t hostBus,
    input wire logic [7:0] rdData
);
    initial begin
        hostBus = '0;
    end
    // released lines show the inverse so stale data cannot pass
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        hostBus <= '{addr: a, data: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        hostBus <= '{addr: ~a, data: ~d, wr: 1'b0, rd: 1'b0};
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        hostBus <= '{addr: a, data: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        hostBus <= '{addr: ~a, data: 8'hFF, wr: 1'b0, rd: 1'b0};
        #1;
        d = rdData;
    endtask
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a, v[15:8]);
    endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import tcit_pkg::*;
;
    logic sys_clk;
    logic reset;
    logic ctr0Gate;
    logic pacerGateEn;
    logic ctr0ExtClk;
    logic ctr0ClkSelExt;
    logic ctr0Out;
    logic pacerOut;
    logic convStart;
    logic [7:0] rdData;
    logic [7:0] b;
    tcit_bus_t hostBus;
    int nMismatch;
    int checks;
    int n;
    tcit_timer DUT (.sys_clk(sys_clk), .reset(reset), .clkEn(1'b1), .hostBus(hostBus),
        .rdData(rdData), .ctr0Gate(ctr0Gate), .ctr0ExtClk(ctr0ExtClk),
        .ctr0ClkSelExt(ctr0ClkSelExt),
        .ctr0Out(ctr0Out), .pacerGateEn(pacerGateEn), .pacerOut(pacerOut),
        .convStart(convStart));
    tcit_host host (.sys_clk(sys_clk), .hostBus(hostBus), .rdData(rdData));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want) begin
            nMismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic closeOut();
        $display("checks %0d mismatches %0d", checks, nMismatch);
        if (nMismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic gate(input logic g);
        @(posedge sys_clk);
        ctr0Gate <= g;
        #1;
    endtask
    // cycles until ctr0Out (w 0) or convStart (w 1) reaches lvl
    task automatic span(input int w, input logic lvl, output int c);
        c = 0;
        while ((w == 0 ? ctr0Out : convStart) !== lvl) begin
            tick(1);
            c++;
            if (c > 4000) begin
                nMismatch++;
                closeOut();
            end
        end
    endtask
    // k pulses on the external clock, two sys_clk high and two low each
    task automatic pulse(input int k);
        repeat (k) begin
            @(posedge sys_clk);
            ctr0ExtClk <= 1'b1;
            @(posedge sys_clk);
            @(posedge sys_clk);
            ctr0ExtClk <= 1'b0;
            @(posedge sys_clk);
        end
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_mode0();
        host.wr(OFS_CTRL, 8'h30);
        host.wr16(OFS_CNT0, 16'h1234);
        tick(60);
        check(ctr0Out, 1'b0);
        host.wr(OFS_CTRL, 8'h00);
        host.rd(OFS_CNT0, b);
        check(b, 8'h34);
        host.rd(OFS_CNT0, b);
        check(b, 8'h12);
        host.wr16(OFS_CNT0, 16'h0004);
        tick(300);
        check(ctr0Out, 1'b0);
        gate(1'b1);
        span(0, 1'b1, n);
        check(16'(n >= 75 && n <= 105), 16'h0001);
        tick(200);
        check(ctr0Out, 1'b1);
        host.rd(OFS_CTRL, b);
        check(b, 8'h00);
        host.rd(4'h3, b);
        check(b, 8'h00);
        $display("mode 0 and latch done");
    endtask
    task automatic test_wave();
        host.wr(OFS_CTRL, 8'h1E);
        host.wr(OFS_CNT0, 8'h05);
        span(0, 1'b0, n);
        span(0, 1'b1, n);
        check(16'(n), 16'h0032);
        span(0, 1'b0, n);
        check(16'(n), 16'h004B);
        host.wr(OFS_CTRL, 8'h18);
        host.wr(OFS_CNT0, 8'h03);
        span(0, 1'b0, n);
        check(16'(n >= 75 && n <= 101), 16'h0001);
        span(0, 1'b1, n);
        check(16'(n), 16'h0019);
        tick(200);
        check(ctr0Out, 1'b1);
        host.wr(OFS_CTRL, 8'h12);
        host.wr(OFS_CNT0, 8'h02);
        gate(1'b0);
        gate(1'b1);
        span(0, 1'b0, n);
        check(16'(n <= 26), 16'h0001);
        span(0, 1'b1, n);
        check(16'(n), 16'h0032);
        $display("waves done");
    endtask
    task automatic test_pacer();
        host.wr(OFS_CTRL, 8'h7C);
        host.wr16(OFS_CNT1, 16'h0002);
        host.wr(OFS_CTRL, 8'hB4);
        host.wr16(OFS_CNT2, 16'h0003);
        pacerGateEn <= 1'b1;
        span(1, 1'b1, n);
        tick(1);
        span(1, 1'b1, n);
        check(16'(n + 1), 16'h0096);
        pacerGateEn <= 1'b0;
        tick(60);
        check(pacerOut, 1'b1);
        $display("pacer done");
    endtask
    task automatic test_ext();
        ctr0ClkSelExt <= 1'b1;
        host.wr(OFS_CTRL, 8'h1B);
        host.wr(OFS_CNT0, 8'h10);
        gate(1'b0);
        gate(1'b1);
        pulse(10);
        check(ctr0Out, 1'b1);
        pulse(1);
        check(ctr0Out, 1'b0);
        pulse(1);
        check(ctr0Out, 1'b1);
        host.wr(OFS_CTRL, 8'hE2);
        host.rd(OFS_CNT0, b);
        check(b, 8'h9B);
        ctr0ClkSelExt <= 1'b0;
        $display("external clock and read-back done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        reset = 1'b1;
        ctr0Gate = 1'b0;
        pacerGateEn = 1'b0;
        ctr0ExtClk = 1'b0;
        ctr0ClkSelExt = 1'b0;
        nMismatch = 0;
        checks = 0;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        tick(1);
        check({rdData, ctr0Out, pacerOut, convStart}, 11'h006);
        test_mode0();
        test_wave();
        test_pacer();
        test_ext();
        closeOut();
    end
endmodule
`default_nettype wire
